//--- src/dps_regs.vh
`ifndef DPS_REGS_VH
`define DPS_REGS_VH

// Register byte addresses
`define DPS_ADDR_CTRL      12'h000
`define DPS_ADDR_THERM     12'h004
`define DPS_ADDR_WARN      12'h008
`define DPS_ADDR_TRIP      12'h00C
`define DPS_ADDR_STALL     12'h010
`define DPS_ADDR_OUTSEL    12'h014
`define DPS_ADDR_STATUS    12'h018
`define DPS_ADDR_IRQ_STAT  12'h01C
`define DPS_ADDR_IRQ_MASK  12'h020

// Field positions
`define DPS_CTRL_THERM_EN  0
`define DPS_CTRL_COOLING   1
`define DPS_CTRL_TRIP_EN   2
`define DPS_CTRL_CLR_TRIP  3

// Reset values
`define DPS_RST_THERM_1MIN 8'h96
`define DPS_RST_THERM_CONT 8'h64
`define DPS_RST_WARN_LVL   8'h96
`define DPS_RST_WARN_TIME  8'h0A
`define DPS_RST_TRIP_LVL   8'hB4
`define DPS_RST_TRIP_TIME  8'h3C
`define DPS_RST_STALL_MASK 3'h3
`define DPS_RST_STALL_LVL  8'h96
`define DPS_RST_MO_SEL     5'h0C
`define DPS_RST_RELAY_SEL  5'h11
`define DPS_RST_FAULT_MASK 2'h0

// Ranges
`define DPS_CONT_MIN       8'h32
`define DPS_CONT_MAX       8'h96
`define DPS_WARN_LVL_MIN   8'h1E
`define DPS_WARN_LVL_MAX   8'h96
`define DPS_WARN_TIME_MAX  8'h1E
`define DPS_TRIP_LVL_MIN   8'h1E
`define DPS_TRIP_LVL_MAX   8'hC8
`define DPS_TRIP_TIME_MAX  8'h3C
`define DPS_STALL_LVL_MIN  8'h1E
`define DPS_STALL_LVL_MAX  8'h96
`define DPS_SEL_MAX        5'h11

// Output codes
`define DPS_CODE_OL        5'h05
`define DPS_CODE_STALL     5'h07
`define DPS_CODE_LVT       5'h09
`define DPS_CODE_CMD_LOSS  5'h0B
`define DPS_CODE_RUN       5'h0C
`define DPS_CODE_STOP      5'h0D
`define DPS_CODE_CONST     5'h0E
`define DPS_CODE_WAIT_RUN  5'h10
`define DPS_CODE_FAULT     5'h11

// Timing
`define DPS_CLK_HZ         100000000
`define DPS_SEC_TICKS      (`DPS_CLK_HZ / 1)
`define DPS_THERM_WINDOW_S 60

`endif

//--- src/dps_protect.v
// Contract
// - Code 11 asserts output while frequency command is lost.
// - Code 12 asserts output while running and generating output voltage.
// - Code 16 asserts output while healthy and waiting for run command.
// - Code 17 follows fault mask; mask 2 means any trip except low voltage.
// - Thermal enabled: time-inverse model cuts output after sustained overcurrent.
// - One-minute level in percent, default 150, not below continuous level.
// - Continuous level 50 to 150, default 100, not above one-minute level.
// - Cooling type 0 derates at low speed; 1 is speed independent.
// - Warning level percent of rated current, 30 to 150, default 150.
// - Code 5 routes overload warning to the output.
// - Trip enabled: cut output after current above level for trip time.
// - Accel with mask bit 0: hold ramp while current above stall level.
// - Constant speed with mask bit 1: reduce frequency while current high.
// - Decel with mask bit 2: pause ramp while DC link voltage high.
// - Stall mask 0 to 7, default 3; bits accel, constant, decel.
// - Code 7 indicates stall prevention acting.
// - Stall action may lengthen ramps beyond configured ramp time.
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "dps_regs.vh"

module dps_protect #(
    parameter SEC_TICKS = `DPS_SEC_TICKS,
    parameter [7:0] THERM_SCALE = `DPS_THERM_WINDOW_S
) (
    input wire i_clk,
    input wire i_reset,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [11:0] i_paddr,
    input wire [31:0] i_pwdata,
    output reg [31:0] o_prdata,
    output reg o_pready,
    output reg o_pslverr,
    input wire [7:0] i_current_pct,
    input wire i_dc_link_high,
    input wire i_run_cmd,
    input wire i_voltage_out,
    input wire i_freq_cmd_lost,
    input wire i_accel,
    input wire i_decel,
    input wire i_low_speed,
    input wire i_low_voltage_trip,
    input wire i_other_trip,
    output reg o_output_cut,
    output reg o_ramp_hold,
    output reg o_freq_reduce,
    output reg o_transistor_status_output,
    output reg o_status_relay,
    output reg o_irq
);

    // ============================================================
    // Configuration registers
    reg therm_en_reg;
    reg cooling_reg;
    reg trip_en_reg;
    reg [7:0] one_min_reg;
    reg [7:0] cont_reg;
    reg [7:0] warn_lvl_reg;
    reg [7:0] warn_time_reg;
    reg [7:0] trip_lvl_reg;
    reg [7:0] trip_time_reg;
    reg [2:0] stall_mask_reg;
    reg [7:0] stall_lvl_reg;
    reg [4:0] mo_sel_reg;
    reg [4:0] relay_sel_reg;
    reg [1:0] fault_mask_reg;
    reg [3:0] irq_stat_reg;
    reg [3:0] irq_mask_reg;

    // ============================================================
    // Protection state
    reg [31:0] sec_cnt_reg;
    reg sec_tick_reg;
    reg [7:0] warn_sec_reg;
    reg [7:0] trip_sec_reg;
    reg [23:0] heat_reg;
    reg warn_reg;
    reg therm_trip_reg;
    reg ol_trip_reg;
    reg stall_reg;

    wire wr = i_psel && i_penable && i_pwrite && o_pready;
    wire rd_setup = i_psel && !i_penable;

    function in_range8;
        input [7:0] v;
        input [7:0] lo;
        input [7:0] hi;
        begin
            in_range8 = (v >= lo) && (v <= hi);
        end
    endfunction

    // Full 16-bit square, no truncation of the product
    function [15:0] sq8;
        input [7:0] v;
        begin
            sq8 = {8'h0, v} * {8'h0, v};
        end
    endfunction

    function sel_out;
        input [4:0] code;
        input warn;
        input stall;
        input tripped;
        input [1:0] fmask;
        reg any_trip;
        begin
            any_trip = tripped || i_other_trip || i_low_voltage_trip;
            case (code)
                `DPS_CODE_OL: sel_out = warn;
                `DPS_CODE_STALL: sel_out = stall;
                `DPS_CODE_LVT: sel_out = i_low_voltage_trip;
                `DPS_CODE_CMD_LOSS: sel_out = i_freq_cmd_lost;
                `DPS_CODE_RUN: sel_out = i_run_cmd && i_voltage_out;
                `DPS_CODE_STOP: sel_out = !i_voltage_out;
                `DPS_CODE_CONST: sel_out = i_voltage_out && !i_accel && !i_decel;
                `DPS_CODE_WAIT_RUN: sel_out = !any_trip && !i_run_cmd;
                `DPS_CODE_FAULT: begin
                    case (fmask)
                        2'h2: sel_out = tripped || i_other_trip;
                        default: sel_out = any_trip;
                    endcase
                end
                default: sel_out = 1'b0;
            endcase
        end
    endfunction

    // ============================================================
    // APB slave
    wire [7:0] wb = i_pwdata[7:0];
    wire [7:0] wb1 = i_pwdata[15:8];
    always @(posedge i_clk) begin
        if (i_reset) begin
            therm_en_reg <= 1'b0;
            cooling_reg <= 1'b0;
            trip_en_reg <= 1'b0;
            one_min_reg <= `DPS_RST_THERM_1MIN;
            cont_reg <= `DPS_RST_THERM_CONT;
            warn_lvl_reg <= `DPS_RST_WARN_LVL;
            warn_time_reg <= `DPS_RST_WARN_TIME;
            trip_lvl_reg <= `DPS_RST_TRIP_LVL;
            trip_time_reg <= `DPS_RST_TRIP_TIME;
            stall_mask_reg <= `DPS_RST_STALL_MASK;
            stall_lvl_reg <= `DPS_RST_STALL_LVL;
            mo_sel_reg <= `DPS_RST_MO_SEL;
            relay_sel_reg <= `DPS_RST_RELAY_SEL;
            fault_mask_reg <= `DPS_RST_FAULT_MASK;
            irq_mask_reg <= 4'h0;
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h0;
        end else begin
            o_pready <= i_psel && !i_penable;
            o_pslverr <= 1'b0;
            if (rd_setup) begin
                case (i_paddr)
                    `DPS_ADDR_CTRL: o_prdata <= {29'h0, trip_en_reg, cooling_reg, therm_en_reg};
                    `DPS_ADDR_THERM: o_prdata <= {16'h0, cont_reg, one_min_reg};
                    `DPS_ADDR_WARN: o_prdata <= {16'h0, warn_time_reg, warn_lvl_reg};
                    `DPS_ADDR_TRIP: o_prdata <= {16'h0, trip_time_reg, trip_lvl_reg};
                    `DPS_ADDR_STALL: o_prdata <= {16'h0, stall_lvl_reg, 5'h0, stall_mask_reg};
                    `DPS_ADDR_OUTSEL: o_prdata <= {14'h0, fault_mask_reg, 3'h0, relay_sel_reg,
                        3'h0, mo_sel_reg};
                    `DPS_ADDR_STATUS: o_prdata <= {26'h0, o_status_relay,
                        o_transistor_status_output, stall_reg, ol_trip_reg, therm_trip_reg,
                        warn_reg};
                    `DPS_ADDR_IRQ_STAT: o_prdata <= {28'h0, irq_stat_reg};
                    `DPS_ADDR_IRQ_MASK: o_prdata <= {28'h0, irq_mask_reg};
                    default: o_prdata <= 32'h0;
                endcase
            end
            if (rd_setup) begin
                case (i_paddr)
                    `DPS_ADDR_CTRL, `DPS_ADDR_THERM, `DPS_ADDR_WARN, `DPS_ADDR_TRIP,
                    `DPS_ADDR_STALL, `DPS_ADDR_OUTSEL, `DPS_ADDR_STATUS,
                    `DPS_ADDR_IRQ_STAT, `DPS_ADDR_IRQ_MASK: o_pslverr <= 1'b0;
                    default: o_pslverr <= 1'b1;
                endcase
            end
            if (wr) begin
                case (i_paddr)
                    `DPS_ADDR_CTRL: begin
                        therm_en_reg <= i_pwdata[`DPS_CTRL_THERM_EN];
                        cooling_reg <= i_pwdata[`DPS_CTRL_COOLING];
                        trip_en_reg <= i_pwdata[`DPS_CTRL_TRIP_EN];
                    end
                    `DPS_ADDR_THERM: begin
                        // Pair rejected unless cont in range and not above one-minute
                        if (in_range8(wb1, `DPS_CONT_MIN, `DPS_CONT_MAX) && wb >= wb1) begin
                            one_min_reg <= wb;
                            cont_reg <= wb1;
                        end
                    end
                    `DPS_ADDR_WARN: begin
                        if (in_range8(wb, `DPS_WARN_LVL_MIN, `DPS_WARN_LVL_MAX) &&
                            wb1 <= `DPS_WARN_TIME_MAX) begin
                            warn_lvl_reg <= wb;
                            warn_time_reg <= wb1;
                        end
                    end
                    `DPS_ADDR_TRIP: begin
                        if (in_range8(wb, `DPS_TRIP_LVL_MIN, `DPS_TRIP_LVL_MAX) &&
                            wb1 <= `DPS_TRIP_TIME_MAX) begin
                            trip_lvl_reg <= wb;
                            trip_time_reg <= wb1;
                        end
                    end
                    `DPS_ADDR_STALL: begin
                        stall_mask_reg <= i_pwdata[2:0];
                        if (in_range8(wb1, `DPS_STALL_LVL_MIN, `DPS_STALL_LVL_MAX))
                            stall_lvl_reg <= wb1;
                    end
                    `DPS_ADDR_OUTSEL: begin
                        if (i_pwdata[4:0] <= `DPS_SEL_MAX)
                            mo_sel_reg <= i_pwdata[4:0];
                        if (i_pwdata[12:8] <= `DPS_SEL_MAX)
                            relay_sel_reg <= i_pwdata[12:8];
                        fault_mask_reg <= i_pwdata[17:16];
                    end
                    `DPS_ADDR_IRQ_MASK: irq_mask_reg <= i_pwdata[3:0];
                    default: ;
                endcase
            end
        end
    end

    // ============================================================
    // Second tick
    always @(posedge i_clk) begin
        if (i_reset) begin
            sec_cnt_reg <= 32'h0;
            sec_tick_reg <= 1'b0;
        end else if (sec_cnt_reg >= SEC_TICKS - 1) begin
            sec_cnt_reg <= 32'h0;
            sec_tick_reg <= 1'b1;
        end else begin
            sec_cnt_reg <= sec_cnt_reg + 32'h1;
            sec_tick_reg <= 1'b0;
        end
    end

    // ============================================================
    // Thermal, warning and trip
    wire [7:0] cont_eff = (!cooling_reg && i_low_speed) ?
        (cont_reg - {1'b0, cont_reg[7:1]} + {2'h0, cont_reg[7:2]}) : cont_reg;
    wire [7:0] excess = (i_current_pct > cont_eff) ? (i_current_pct - cont_eff) : 8'h0;
    wire [7:0] span = (one_min_reg > cont_eff) ? (one_min_reg - cont_eff) : 8'h1;
    wire [15:0] span_sq = sq8(span);
    wire [15:0] excess_sq = sq8(excess);
    // Heat limit: span^2 * window seconds, excess^2 added each second
    wire [23:0] heat_lim = {8'h0, span_sq} * {16'h0, THERM_SCALE};
    wire clr_trip = wr && (i_paddr == `DPS_ADDR_CTRL) && i_pwdata[`DPS_CTRL_CLR_TRIP];
    wire do_stall_acc = stall_mask_reg[0] && i_accel && (i_current_pct > stall_lvl_reg);
    wire do_stall_const = stall_mask_reg[1] && !i_accel && !i_decel && i_voltage_out &&
        (i_current_pct > stall_lvl_reg);
    wire do_stall_dec = stall_mask_reg[2] && i_decel && i_dc_link_high;
    wire [3:0] events = {stall_reg, ol_trip_reg, therm_trip_reg, warn_reg};
    wire [3:0] wr_clear = (wr && i_paddr == `DPS_ADDR_IRQ_STAT) ? i_pwdata[3:0] : 4'h0;
    wire trip_any = therm_trip_reg || ol_trip_reg;

    always @(posedge i_clk) begin
        if (i_reset) begin
            heat_reg <= 24'h0;
            warn_sec_reg <= 8'h0;
            trip_sec_reg <= 8'h0;
            warn_reg <= 1'b0;
            therm_trip_reg <= 1'b0;
            ol_trip_reg <= 1'b0;
            stall_reg <= 1'b0;
            irq_stat_reg <= 4'h0;
            o_output_cut <= 1'b0;
            o_ramp_hold <= 1'b0;
            o_freq_reduce <= 1'b0;
            o_transistor_status_output <= 1'b0;
            o_status_relay <= 1'b0;
            o_irq <= 1'b0;
        end else begin
            // Model idle while thermal protection is off
            if (!therm_en_reg) begin
                heat_reg <= 24'h0;
            end else if (sec_tick_reg) begin
                // Time-inverse accumulation, cooling when below continuous level
                if (excess != 8'h0) begin
                    if (heat_reg < heat_lim)
                        heat_reg <= heat_reg + {8'h0, excess_sq};
                end else if (heat_reg > {8'h0, span_sq}) begin
                    heat_reg <= heat_reg - {8'h0, span_sq};
                end else begin
                    heat_reg <= 24'h0;
                end
            end
            if (sec_tick_reg) begin
                // Count one past the set time so a part second never counts
                if (i_current_pct > warn_lvl_reg) begin
                    if (warn_sec_reg <= warn_time_reg)
                        warn_sec_reg <= warn_sec_reg + 8'h1;
                end else begin
                    warn_sec_reg <= 8'h0;
                end
                if (i_current_pct > trip_lvl_reg) begin
                    if (trip_sec_reg <= trip_time_reg)
                        trip_sec_reg <= trip_sec_reg + 8'h1;
                end else begin
                    trip_sec_reg <= 8'h0;
                end
            end
            warn_reg <= (i_current_pct > warn_lvl_reg) &&
                (warn_sec_reg > warn_time_reg);
            if (therm_en_reg && heat_reg >= heat_lim && excess != 8'h0)
                therm_trip_reg <= 1'b1;
            else if (clr_trip)
                therm_trip_reg <= 1'b0;
            if (trip_en_reg && i_current_pct > trip_lvl_reg && trip_sec_reg > trip_time_reg)
                ol_trip_reg <= 1'b1;
            else if (clr_trip)
                ol_trip_reg <= 1'b0;
            o_output_cut <= trip_any;
            // Ramp hold lets accel or decel run past the set ramp time
            o_ramp_hold <= do_stall_acc || do_stall_dec;
            o_freq_reduce <= do_stall_const;
            stall_reg <= do_stall_acc || do_stall_const || do_stall_dec;
            o_transistor_status_output <= sel_out(mo_sel_reg, warn_reg, stall_reg,
                trip_any, fault_mask_reg);
            o_status_relay <= sel_out(relay_sel_reg, warn_reg, stall_reg,
                trip_any, fault_mask_reg);
            // Set wins over a simultaneous write-one clear
            irq_stat_reg <= (irq_stat_reg & ~wr_clear) | events;
            o_irq <= |(irq_stat_reg & irq_mask_reg);
        end
    end

endmodule

//--- test/dps_protect_monitor.sv
`timescale 1ns/10ps
// ====
// Port checker
module dps_chk (
    input wire i_clk,
    input wire i_reset,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [11:0] i_paddr,
    input wire o_pready,
    input wire o_pslverr,
    input wire [7:0] i_current_pct,
    input wire i_dc_link_high,
    input wire i_accel,
    input wire i_decel,
    input wire o_output_cut,
    input wire o_ramp_hold,
    input wire o_freq_reduce
);
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (i_reset);
    AST_ANSWER: assert property (i_psel && !i_penable |=> o_pready)
        else $error("pready missing after setup");
    AST_ONE_CYCLE: assert property (o_pready |=> !o_pready)
        else $error("pready longer than one cycle");
    AST_ERR_PAIR: assert property (o_pslverr |-> o_pready)
        else $error("pslverr without pready");
    AST_UNMAPPED: assert property (i_psel && !i_penable && i_paddr > 12'h020 |=> o_pslverr)
        else $error("unmapped access not refused");
    AST_CUT_HOLD: assert property (
        o_output_cut && !i_psel && !$past(i_psel) && !$past(i_psel, 2) |=> o_output_cut)
        else $error("trip released without clear");
    AST_LOW_CURRENT: assert property (
        (i_current_pct < 8'h1E && !i_decel)[*3] |-> !o_ramp_hold && !o_freq_reduce)
        else $error("stall action at low current");
    AST_CONST_NO_HOLD: assert property (
        (!i_accel && !i_decel)[*3] |-> !o_ramp_hold)
        else $error("ramp hold outside ramps");
    AST_RAMP_NO_REDUCE: assert property (
        (i_accel || i_decel)[*3] |-> !o_freq_reduce)
        else $error("frequency reduce during ramp");
    AST_DECEL_DC: assert property (
        (i_decel && !i_accel && !i_dc_link_high)[*3] |-> !o_ramp_hold)
        else $error("decel hold with link voltage low");
endmodule

bind dps_protect dps_chk u_chk (.i_clk(i_clk), .i_reset(i_reset), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_current_pct(i_current_pct), .i_dc_link_high(i_dc_link_high),
    .i_accel(i_accel), .i_decel(i_decel), .o_output_cut(o_output_cut),
    .o_ramp_hold(o_ramp_hold), .o_freq_reduce(o_freq_reduce));

//--- test/dps_seq_ctrl.sv
`timescale 1ns/10ps
// ====
// External sequence controller, counts output activations
module dps_seq_ctrl (
    input wire i_clk,
    input wire i_reset,
    input wire i_mo,
    output logic [7:0] o_mo_rises
);
    logic mo_reg;
    always @(posedge i_clk) begin
        mo_reg <= i_reset ? 1'b0 : i_mo;
        if (i_reset)
            o_mo_rises <= 8'h00;
        else if (i_mo && !mo_reg)
            o_mo_rises <= o_mo_rises + 8'h01;
    end
endmodule

//--- test/tb.sv
`timescale 1ns/10ps
module tb;
    localparam int ST = 10;
    logic i_clk = 0, i_reset = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
    logic [11:0] i_paddr = '0;
    logic [31:0] i_pwdata = '0;
    logic [7:0] i_current_pct = '0;
    logic i_dc_link_high = 0, i_run_cmd = 0, i_voltage_out = 0, i_freq_cmd_lost = 0;
    logic i_accel = 0, i_decel = 0, i_low_speed = 0, i_low_voltage_trip = 0, i_other_trip = 0;
    wire [31:0] o_prdata;
    wire o_pready, o_pslverr, o_output_cut, o_ramp_hold, o_freq_reduce, o_irq;
    wire o_transistor_status_output, o_status_relay;
    wire [7:0] mo_rises;
    int err_total = 0, comparisons = 0, cyc = 0, n;
    logic [64:0] exp_q[$];
    logic [64:0] e;
    logic [12:0] tbl [12] = '{{5'h0B, 2'h0, 5'h10, 1'b1}, {5'h0B, 2'h0, 5'h00, 1'b0},
        {5'h0C, 2'h0, 5'h0C, 1'b1}, {5'h0C, 2'h0, 5'h08, 1'b0}, {5'h10, 2'h0, 5'h00, 1'b1},
        {5'h10, 2'h0, 5'h08, 1'b0}, {5'h11, 2'h2, 5'h02, 1'b0}, {5'h11, 2'h2, 5'h01, 1'b1},
        {5'h11, 2'h0, 5'h02, 1'b1}, {5'h0D, 2'h0, 5'h00, 1'b1}, {5'h0E, 2'h0, 5'h04, 1'b1},
        {5'h09, 2'h0, 5'h02, 1'b1}};
    logic [4:0] c, ins;
    logic [1:0] fm;
    logic x1;

    dps_protect #(.SEC_TICKS(ST)) u_dut (.i_clk, .i_reset, .i_psel, .i_penable, .i_pwrite,
        .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_current_pct,
        .i_dc_link_high, .i_run_cmd, .i_voltage_out, .i_freq_cmd_lost, .i_accel, .i_decel,
        .i_low_speed, .i_low_voltage_trip, .i_other_trip, .o_output_cut, .o_ramp_hold,
        .o_freq_reduce, .o_transistor_status_output, .o_status_relay, .o_irq);
    dps_seq_ctrl u_seq (.i_clk, .i_reset, .i_mo(o_transistor_status_output),
        .o_mo_rises(mo_rises));

    initial forever #5 i_clk = ~i_clk;

    // ====
    // Checking
    task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] sv);
        comparisons++;
        if (sv !== ex) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, sv);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    always @(posedge i_clk) begin
        if (i_psel && i_penable && o_pready === 1'b1 && !i_pwrite && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            cmp("prdata", e[31:0], o_prdata & e[63:32]);
            cmp("pslverr", {31'h0, e[64]}, {31'h0, o_pslverr});
        end
    end

    always @(posedge i_clk) begin
        cyc++;
        if (cyc > 20000) begin
            err_total++;
            report_and_stop();
        end
    end

    // ====
    // APB master
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] ex, input logic [31:0] m, input logic er);
        if (!w)
            exp_q.push_back({er, m, ex});
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        do @(posedge i_clk); while (o_pready !== 1'b1);
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] ex, input logic [31:0] m);
        apb(1'b0, a, 32'h0, ex, m, 1'b0);
    endtask

    task automatic rd_bad(input logic [11:0] a);
        apb(1'b0, a, 32'h0, 32'h0, 32'h0, 1'b1);
    endtask

    task automatic wait_cut(input int lim);
        n = 0;
        while (o_output_cut !== 1'b1 && n < lim) begin
            @(posedge i_clk);
            n++;
        end
    endtask

    // ====
    // Tests
    initial begin
        n = $urandom(70);
        repeat (3) @(posedge i_clk);
        i_reset <= 1'b0;
        @(posedge i_clk);
        rd(12'h004, 32'h0000_6496, 32'h0000_FFFF);
        rd(12'h008, 32'h0000_0A96, 32'h0000_FFFF);
        rd(12'h00C, 32'h0000_3CB4, 32'h0000_FFFF);
        rd(12'h010, 32'h0000_9603, 32'h0000_FF07);
        rd(12'h014, 32'h0000_110C, 32'h0003_1F1F);
        rd_bad(12'h024);
        wr(12'h004, 32'h0000_97C8);
        rd(12'h004, 32'h0000_6496, 32'h0000_FFFF);
        wr(12'h004, 32'h0000_6450);
        rd(12'h004, 32'h0000_6496, 32'h0000_FFFF);
        $display("test defaults done");
        foreach (tbl[k]) begin
            {c, fm, ins, x1} = tbl[k];
            wr(12'h014, {14'h0, fm, 3'h0, c, 3'h0, c});
            {i_freq_cmd_lost, i_run_cmd, i_voltage_out, i_low_voltage_trip, i_other_trip} <= ins;
            repeat (3) @(posedge i_clk);
            rd(12'h018, {26'h0, x1, x1, 4'h0},
                32'h30);
        end
        {i_freq_cmd_lost, i_run_cmd, i_voltage_out, i_low_voltage_trip, i_other_trip} <= 5'h00;
        cmp("mo_rises", 32'h1, 32'(mo_rises != 0));
        $display("test output codes done");
        wr(12'h008, 32'h0000_0264);
        wr(12'h014, 32'h0000_0505);
        wr(12'h020, 32'h1);
        i_current_pct <= 8'h65 + 8'($urandom % 99);
        n = 0;
        while (o_transistor_status_output !== 1'b1 && n < 100) begin
            @(posedge i_clk);
            n++;
        end
        cmp("warn_delay", 32'h1,
            32'(n >= ST && n <= 3 * ST + 5));
        cmp("relay", 32'h1, 32'(o_status_relay));
        wr(12'h01C, 32'h1);
        repeat (2) @(posedge i_clk);
        cmp("irq_set", 32'h1, 32'(o_irq));
        wr(12'h020, 32'h0);
        repeat (2) @(posedge i_clk);
        cmp("irq_masked", 32'h0, 32'(o_irq));
        i_current_pct <= 8'h20;
        repeat (4) @(posedge i_clk);
        wr(12'h01C, 32'h1F);
        wr(12'h020, 32'h1);
        repeat (2) @(posedge i_clk);
        cmp("irq_clear", 32'h0, 32'(o_irq));
        $display("test warning done");
        wr(12'h014, 32'h0000_0707);
        i_current_pct <= 8'h65 + 8'($urandom % 99);
        i_voltage_out <= 1'b1;
        for (int m = 0; m < 2; m++) begin
            wr(12'h010, m ? 32'h0000_6402 : 32'h0000_6407);
            for (int p = 0; p < 3; p++) begin
                {i_accel, i_decel} <= (p == 0) ? 2'b10 : (p == 2) ? 2'b01 : 2'b00;
                i_dc_link_high <= (p == 2);
                repeat (4) @(posedge i_clk);
                cmp("ramp_hold", 32'(p != 1 && m == 0),
                    32'(o_ramp_hold));
                cmp("freq_reduce", 32'(p == 1), 32'(o_freq_reduce));
                cmp("stall_out", 32'(p == 1 || m == 0), 32'(o_status_relay));
            end
        end
        {i_accel, i_decel, i_dc_link_high, i_voltage_out} <= 4'h0;
        i_current_pct <= 8'h20;
        $display("test stall done");
        wr(12'h00C, 32'h0000_0164);
        wr(12'h000, 32'h4);
        i_current_pct <= 8'hC8;
        wait_cut(60);
        cmp("trip_delay", 32'h1, 32'(n >= ST - 2 && n <= 2 * ST + 5));
        i_current_pct <= 8'h20;
        wr(12'h000, 32'h8);
        repeat (3) @(posedge i_clk);
        cmp("trip_clear", 32'h0, 32'(o_output_cut));
        $display("test overload trip done");
        wr(12'h004, 32'h0000_6465);
        {i_low_speed, i_decel} <= 2'h3;
        i_current_pct <= 8'h5A;
        wr(12'h000, 32'h3);
        repeat (6 * ST) @(posedge i_clk);
        cmp("fan_cooled", 32'h0, 32'(o_output_cut));
        wr(12'h000, 32'h1);
        // 75 percent of 100 against 90: 225 per second up to 26*26*60
        wait_cut(200 * ST);
        cmp("self_cooled", 32'h1,
            32'(o_output_cut === 1'b1 && n >= 170 * ST));
        rd(12'h018, 32'h2, 32'h2);
        i_current_pct <= 8'h20;
        wr(12'h000, 32'h8);
        repeat (3) @(posedge i_clk);
        cmp("therm_clear", 32'h0, 32'(o_output_cut));
        $display("test thermal done");
        report_and_stop();
    end
endmodule
